// >>> logic/sbcsm_bank_tracker.sv
// Per-bank command decoding, legality and state tracking for a four-bank synchronous DRAM.
`timescale 1ns/10ps
module sbcsm_bank_tracker
    import sbcsm_pkg::*;
#(
    parameter int CNT_W = COUNTER_WIDTH,
    parameter int PRE_CYC = PRECHARGE_CYCLES,
    parameter int ACT_CYC = ACTIVATE_CYCLES,
    parameter int RFC_CYC = REFRESH_CYCLES,
    parameter int MRD_CYC = MODE_LOAD_CYCLES,
    parameter int SRX_CYC = SELF_REFRESH_EXIT_CYCLES,
    parameter int BURST_CYC = BURST_LENGTH_CYCLES
)
(
    // System clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Memory link
    input wire logic mem_clock,
    input wire sbcsm_pins_type pins,
    // Link-domain observation
    output sbcsm_bank_state_type [NUM_BANKS-1:0] bank_state,
    output sbcsm_dev_state_type dev_state,
    output logic command_illegal,
    // System-domain view
    output sbcsm_status_type status,
    output logic status_valid
);

    ////////////////////////////////////////////////////////////////////////////////
    // Every window must fit the counters and last at least one cycle.
    if (PRE_CYC < 1 || ACT_CYC < 1 || RFC_CYC < 1 || MRD_CYC < 1 || SRX_CYC < 1 ||
        BURST_CYC < 1 || (BURST_CYC + PRE_CYC) >= (2 ** CNT_W) ||
        RFC_CYC >= (2 ** CNT_W) || MRD_CYC >= (2 ** CNT_W) || SRX_CYC >= (2 ** CNT_W) ||
        ACT_CYC >= (2 ** CNT_W))
    begin : g_bad_timing
        $error("sbcsm_bank_tracker: timing counts do not fit the counter width");
    end

    localparam logic [CNT_W-1:0] PRE_LOAD = CNT_W'(PRE_CYC);
    localparam logic [CNT_W-1:0] ACT_LOAD = CNT_W'(ACT_CYC);
    localparam logic [CNT_W-1:0] RFC_LOAD = CNT_W'(RFC_CYC);
    localparam logic [CNT_W-1:0] MRD_LOAD = CNT_W'(MRD_CYC);
    localparam logic [CNT_W-1:0] SRX_LOAD = CNT_W'(SRX_CYC);
    localparam logic [CNT_W-1:0] BURST_LOAD = CNT_W'(BURST_CYC);
    localparam logic [CNT_W-1:0] BURST_AP_LOAD = CNT_W'(BURST_CYC + PRE_CYC);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(1);

    // A timed state whose counter shows its last cycle already acts as its successor.
    function automatic sbcsm_bank_state_type bank_effective(input sbcsm_bank_state_type s,
                                                           input logic [CNT_W-1:0] c);
        sbcsm_bank_state_type e;
        e = s;
        if (c == CNT_LAST)
        begin
            unique case (s)
                BANK_ACTIVATING, BANK_READ, BANK_WRITE: e = BANK_ACTIVE;
                BANK_PRECHARGING, BANK_READ_AP, BANK_WRITE_AP: e = BANK_IDLE;
                BANK_IDLE, BANK_ACTIVE: e = s;
            endcase
        end
        return e;
    endfunction : bank_effective

    // States from which a bank may be precharged.
    function automatic logic precharge_allowed(input sbcsm_bank_state_type s);
        return s inside {BANK_IDLE, BANK_ACTIVE, BANK_READ, BANK_WRITE};
    endfunction : precharge_allowed

    // Shared down-counter step.
    function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] c);
        return (c != '0) ? c - 1'b1 : '0;
    endfunction : count_down

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release, one copy per clock domain.
    logic [1:0] sys_rst_q;
    logic [1:0] link_rst_q;
    logic sys_rst_n;
    logic link_rst_n;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            sys_rst_q <= 2'h0;
        else
            sys_rst_q <= {sys_rst_q[0], 1'b1};
    end

    always_ff @(posedge mem_clock or negedge rstn)
    begin
        if (!rstn)
            link_rst_q <= 2'h0;
        else
            link_rst_q <= {link_rst_q[0], 1'b1};
    end

    assign sys_rst_n = sys_rst_q[1];
    assign link_rst_n = link_rst_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Link-domain state. Pins are driven on the memory clock, so they are sampled directly.
    sbcsm_bank_state_type [NUM_BANKS-1:0] bank_q;
    sbcsm_bank_state_type [NUM_BANKS-1:0] bank_d;
    sbcsm_bank_state_type [NUM_BANKS-1:0] eff;
    logic [NUM_BANKS-1:0][CNT_W-1:0] cnt_q;
    logic [NUM_BANKS-1:0][CNT_W-1:0] cnt_d;
    sbcsm_dev_state_type dev_q;
    sbcsm_dev_state_type dev_d;
    sbcsm_dev_state_type dev_eff;
    logic [CNT_W-1:0] dev_cnt_q;
    logic [CNT_W-1:0] dev_cnt_d;
    logic cke_prev_q;
    logic illegal_q;
    logic illegal_seen_q;
    logic [BANK_SEL_W-1:0] last_bank_q;
    sbcsm_cmd_type cmd;
    sbcsm_bank_state_type tgt;
    logic [BANK_SEL_W-1:0] bank_addr;
    logic all_idle;
    logic pre_all_ok;
    logic decode_on;
    logic executable;
    logic cmd_legal;
    logic exec_cmd;
    logic illegal_now;
    logic dev_busy;

    assign cmd = decode_command(pins);
    assign bank_addr = {pins.bank_select_high, pins.bank_select_low};
    assign tgt = eff[bank_addr];
    assign executable = (cmd != CMD_INHIBIT) && (cmd != CMD_NOP);

    // Device-wide windows end the same way as bank windows.
    assign dev_eff = (dev_q inside {DEV_REFRESHING, DEV_MODE_LOAD, DEV_PRECHARGE_ALL, DEV_SR_EXIT}
                      && dev_cnt_q == CNT_LAST) ? DEV_NORMAL : dev_q;
    assign decode_on = cke_prev_q && pins.cke &&
                       !(dev_eff inside {DEV_SELF_REFRESH, DEV_SR_EXIT});
    assign dev_busy = (dev_eff != DEV_NORMAL);

    // Whole-device views of the effective bank states.
    always_comb
    begin
        all_idle = 1'b1;
        pre_all_ok = 1'b1;
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            eff[b] = bank_effective(bank_q[b], cnt_q[b]);
            if (eff[b] != BANK_IDLE)
                all_idle = 1'b0;
            if (!precharge_allowed(eff[b]))
                pre_all_ok = 1'b0;
        end
    end

    // Legality of the command against the addressed bank and the device window.
    always_comb
    begin
        cmd_legal = 1'b1;
        unique case (cmd)
            CMD_INHIBIT, CMD_NOP: cmd_legal = 1'b1;
            CMD_ACTIVE: cmd_legal = (tgt == BANK_IDLE);
            CMD_READ, CMD_WRITE: cmd_legal = tgt inside {BANK_ACTIVE, BANK_READ, BANK_WRITE};
            CMD_PRECHARGE: cmd_legal = pins.auto_precharge_bit ? pre_all_ok : precharge_allowed(tgt);
            CMD_BURST_TERM: cmd_legal = 1'b1;
            CMD_REFRESH, CMD_MODE_LOAD: cmd_legal = all_idle;
        endcase
        if (dev_busy && executable)
            cmd_legal = 1'b0;
    end

    // Illegal combinations are flagged and otherwise ignored; running bank and device windows keep counting down.
    assign exec_cmd = decode_on && executable && cmd_legal;
    assign illegal_now = decode_on && executable && !cmd_legal;

    ////////////////////////////////////////////////////////////////////////////////
    // Bank next state; other banks keep working while one is addressed.
    always_comb
    begin
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            bank_d[b] = eff[b];
            cnt_d[b] = count_down(cnt_q[b]);
            if (exec_cmd)
            begin
                unique case (cmd)
                    CMD_ACTIVE:
                        if (bank_addr == BANK_SEL_W'(b))
                        begin
                            bank_d[b] = BANK_ACTIVATING;
                            cnt_d[b] = ACT_LOAD;
                        end
                    CMD_READ, CMD_WRITE:
                        if (bank_addr == BANK_SEL_W'(b))
                        begin
                            if (pins.auto_precharge_bit)
                            begin
                                bank_d[b] = (cmd == CMD_WRITE) ? BANK_WRITE_AP : BANK_READ_AP;
                                cnt_d[b] = BURST_AP_LOAD;
                            end
                            else
                            begin
                                bank_d[b] = (cmd == CMD_WRITE) ? BANK_WRITE : BANK_READ;
                                cnt_d[b] = BURST_LOAD;
                            end
                        end
                    CMD_PRECHARGE:
                        if ((pins.auto_precharge_bit || bank_addr == BANK_SEL_W'(b)) &&
                            eff[b] != BANK_IDLE)
                        begin
                            bank_d[b] = BANK_PRECHARGING;
                            cnt_d[b] = PRE_LOAD;
                        end
                    CMD_INHIBIT, CMD_NOP, CMD_BURST_TERM, CMD_REFRESH, CMD_MODE_LOAD: ;
                endcase
                // A new burst elsewhere, or burst terminate, cuts the running burst short.
                if (((cmd == CMD_READ || cmd == CMD_WRITE) && bank_addr != BANK_SEL_W'(b)) ||
                    (cmd == CMD_BURST_TERM && last_bank_q == BANK_SEL_W'(b)))
                begin
                    if (eff[b] inside {BANK_READ, BANK_WRITE})
                    begin
                        bank_d[b] = BANK_ACTIVE;
                        cnt_d[b] = '0;
                    end
                    else if (eff[b] inside {BANK_READ_AP, BANK_WRITE_AP} && cnt_q[b] > PRE_LOAD)
                        cnt_d[b] = PRE_LOAD;
                end
            end
        end
    end

    // Bank registers.
    always_ff @(posedge mem_clock or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            bank_q <= {NUM_BANKS{BANK_RESET_STATE}};
            cnt_q <= '0;
        end
        else
        begin
            bank_q <= bank_d;
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Device-wide windows: refresh, mode load, precharge all, self refresh and its exit.
    always_comb
    begin
        dev_d = dev_eff;
        dev_cnt_d = count_down(dev_cnt_q);
        if (dev_q == DEV_SELF_REFRESH)
        begin
            if (pins.cke)
            begin
                dev_d = DEV_SR_EXIT;
                dev_cnt_d = SRX_LOAD;
            end
        end
        else if (dev_eff == DEV_NORMAL && cke_prev_q && !pins.cke && cmd == CMD_REFRESH && all_idle)
            dev_d = DEV_SELF_REFRESH;
        else if (exec_cmd && cmd == CMD_REFRESH)
        begin
            dev_d = DEV_REFRESHING;
            dev_cnt_d = RFC_LOAD;
        end
        else if (exec_cmd && cmd == CMD_MODE_LOAD)
        begin
            dev_d = DEV_MODE_LOAD;
            dev_cnt_d = MRD_LOAD;
        end
        else if (exec_cmd && cmd == CMD_PRECHARGE && pins.auto_precharge_bit)
        begin
            dev_d = DEV_PRECHARGE_ALL;
            dev_cnt_d = PRE_LOAD;
        end
    end

    always_ff @(posedge mem_clock or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            dev_q <= DEV_RESET_STATE;
            dev_cnt_q <= '0;
        end
        else
        begin
            dev_q <= dev_d;
            dev_cnt_q <= dev_cnt_d;
        end
    end

    // Clock enable history; low after reset so the first edge never decodes.
    always_ff @(posedge mem_clock or negedge link_rst_n)
    begin
        if (!link_rst_n)
            cke_prev_q <= 1'b0;
        else
            cke_prev_q <= pins.cke;
    end

    // Remember which bank started the most recent burst.
    always_ff @(posedge mem_clock or negedge link_rst_n)
    begin
        if (!link_rst_n)
            last_bank_q <= '0;
        else if (exec_cmd && (cmd == CMD_READ || cmd == CMD_WRITE))
            last_bank_q <= bank_addr;
    end

    // Illegal pulse and sticky record; the record only clears at reset.
    always_ff @(posedge mem_clock or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            illegal_q <= 1'b0;
            illegal_seen_q <= 1'b0;
        end
        else
        begin
            illegal_q <= illegal_now;
            illegal_seen_q <= illegal_seen_q | illegal_now;
        end
    end

    assign bank_state = bank_q;
    assign dev_state = dev_q;
    assign command_illegal = illegal_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Status snapshots reach the system clock by handshake; they lag a few cycles.
    sbcsm_status_type link_status;
    logic [$bits(sbcsm_status_type)-1:0] status_raw;

    always_comb
    begin
        link_status.bank = bank_q;
        link_status.dev = dev_q;
        link_status.illegal_seen = illegal_seen_q;
    end

    sbcsm_word_sync #(
        .W($bits(sbcsm_status_type))
    ) u_status_sync (
        .src_clock(mem_clock),
        .src_rst_n(link_rst_n),
        .src_word(link_status),
        .dst_clock(clock),
        .dst_rst_n(sys_rst_n),
        .dst_word(status_raw),
        .dst_strobe(status_valid)
    );

    assign status = sbcsm_status_type'(status_raw);

endmodule : sbcsm_bank_tracker

// >>> logic/sbcsm_word_sync.sv
// Toggle handshake that carries one status word from the link domain to the system domain.
`timescale 1ns/10ps
module sbcsm_word_sync
#(
    parameter int W = 8
)
(
    // Source domain
    input wire logic src_clock,
    input wire logic src_rst_n,
    input wire logic [W-1:0] src_word,
    // Destination domain
    input wire logic dst_clock,
    input wire logic dst_rst_n,
    output logic [W-1:0] dst_word,
    output logic dst_strobe
);

    logic [W-1:0] hold_q;
    logic req_q;
    logic ack_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic req_s1_q;
    logic req_s2_q;
    logic busy;

    ////////////////////////////////////////////////////////////////////////////////
    // The held word only changes while no request is in flight, so it is stable when read.
    assign busy = (req_q != ack_s2_q);

    // Source: capture a fresh snapshot and toggle the request whenever the last one is acknowledged.
    always_ff @(posedge src_clock or negedge src_rst_n)
    begin
        if (!src_rst_n)
        begin
            hold_q <= '0;
            req_q <= 1'b0;
        end
        else if (!busy)
        begin
            hold_q <= src_word;
            req_q <= ~req_q;
        end
    end

    // Source: acknowledge returns through two flip-flops.
    always_ff @(posedge src_clock or negedge src_rst_n)
    begin
        if (!src_rst_n)
        begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end
        else
        begin
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Destination: request passes two flip-flops before it is compared.
    always_ff @(posedge dst_clock or negedge dst_rst_n)
    begin
        if (!dst_rst_n)
        begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end
        else
        begin
            req_s1_q <= req_q;
            req_s2_q <= req_s1_q;
        end
    end

    // Destination: take the word on a new request and echo it as acknowledge.
    always_ff @(posedge dst_clock or negedge dst_rst_n)
    begin
        if (!dst_rst_n)
        begin
            dst_word <= '0;
            ack_q <= 1'b0;
            dst_strobe <= 1'b0;
        end
        else if (req_s2_q != ack_q)
        begin
            dst_word <= hold_q;
            ack_q <= req_s2_q;
            dst_strobe <= 1'b1;
        end
        else
            dst_strobe <= 1'b0;
    end

endmodule : sbcsm_word_sync

// >>> pkg/sbcsm_pkg.sv
// Shared constants, command and state types for the bank command state tracker.
package sbcsm_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Geometry and timing.
    localparam int NUM_BANKS = 4;
    localparam int BANK_SEL_W = 2;
    localparam int COUNTER_WIDTH = 8;
    localparam int LINK_CLOCK_PERIOD_NS = 64;
    localparam int PRECHARGE_TIME_NS = 20;
    localparam int ACTIVATE_TO_ACCESS_TIME_NS = 20;
    localparam int REFRESH_CYCLE_TIME_NS = 66;
    localparam int MODE_LOAD_TIME_NS = 128;
    localparam int SELF_REFRESH_EXIT_TIME_NS = 75;
    localparam int BURST_LENGTH_CYCLES = 4;

    // Least times round up to whole link cycles, never below one.
    function automatic int ns_to_cycles(input int t_ns);
        int c;
        c = (t_ns + LINK_CLOCK_PERIOD_NS - 1) / LINK_CLOCK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cycles

    localparam int PRECHARGE_CYCLES = ns_to_cycles(PRECHARGE_TIME_NS);
    localparam int ACTIVATE_CYCLES = ns_to_cycles(ACTIVATE_TO_ACCESS_TIME_NS);
    localparam int REFRESH_CYCLES = ns_to_cycles(REFRESH_CYCLE_TIME_NS);
    localparam int MODE_LOAD_CYCLES = ns_to_cycles(MODE_LOAD_TIME_NS);
    localparam int SELF_REFRESH_EXIT_CYCLES = ns_to_cycles(SELF_REFRESH_EXIT_TIME_NS);

    ////////////////////////////////////////////////////////////////////////////////
    // Strobe encodings of row, column and write strobes with chip select low.
    localparam logic [2:0] STROBE_NOP = 3'h7;
    localparam logic [2:0] STROBE_ACTIVE = 3'h3;
    localparam logic [2:0] STROBE_REFRESH = 3'h1;
    localparam logic [2:0] STROBE_MODE_LOAD = 3'h0;
    localparam logic [2:0] STROBE_PRECHARGE = 3'h2;
    localparam logic [2:0] STROBE_READ = 3'h5;
    localparam logic [2:0] STROBE_WRITE = 3'h4;
    localparam logic [2:0] STROBE_BURST_TERM = 3'h6;

    typedef enum logic [3:0] {
        CMD_INHIBIT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
        CMD_PRECHARGE, CMD_BURST_TERM, CMD_REFRESH, CMD_MODE_LOAD
    } sbcsm_cmd_type;

    typedef enum logic [2:0] {
        BANK_IDLE, BANK_ACTIVATING, BANK_ACTIVE, BANK_READ, BANK_WRITE,
        BANK_READ_AP, BANK_WRITE_AP, BANK_PRECHARGING
    } sbcsm_bank_state_type;

    typedef enum logic [2:0] {
        DEV_NORMAL, DEV_REFRESHING, DEV_MODE_LOAD, DEV_PRECHARGE_ALL,
        DEV_SELF_REFRESH, DEV_SR_EXIT
    } sbcsm_dev_state_type;

    localparam sbcsm_bank_state_type BANK_RESET_STATE = BANK_IDLE;
    localparam sbcsm_dev_state_type DEV_RESET_STATE = DEV_NORMAL;

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers.
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cke;
        logic auto_precharge_bit;
        logic bank_select_high;
        logic bank_select_low;
    } sbcsm_pins_type;

    typedef struct packed {
        sbcsm_bank_state_type [NUM_BANKS-1:0] bank;
        sbcsm_dev_state_type dev;
        logic illegal_seen;
    } sbcsm_status_type;

    // Chip select high masks every strobe; otherwise the three strobes name the command.
    function automatic sbcsm_cmd_type decode_command(input sbcsm_pins_type p);
        sbcsm_cmd_type c;
        c = CMD_NOP;
        if (p.cs_n)
            c = CMD_INHIBIT;
        else
        begin
            unique case ({p.ras_n, p.cas_n, p.we_n})
                STROBE_NOP: c = CMD_NOP;
                STROBE_ACTIVE: c = CMD_ACTIVE;
                STROBE_REFRESH: c = CMD_REFRESH;
                STROBE_MODE_LOAD: c = CMD_MODE_LOAD;
                STROBE_PRECHARGE: c = CMD_PRECHARGE;
                STROBE_READ: c = CMD_READ;
                STROBE_WRITE: c = CMD_WRITE;
                STROBE_BURST_TERM: c = CMD_BURST_TERM;
            endcase
        end
        return c;
    endfunction : decode_command

endpackage : sbcsm_pkg

// >>> test/sbcsm_asserts.sv
// Link-side checks of the bank tracker.
`timescale 1ns/10ps
module sbcsm_asserts
    import sbcsm_pkg::*;
#(
    parameter int ACT_CYC = 2,
    parameter int PRE_CYC = 2
)
(
    // Link clock and reset
    input wire logic mem_clock,
    input wire logic rstn,
    // Watched pins and outputs
    input wire sbcsm_pins_type pins,
    input wire sbcsm_bank_state_type [NUM_BANKS-1:0] bank_state,
    input wire sbcsm_dev_state_type dev_state,
    input wire logic command_illegal
);
    // The registered state shows a window's successor one edge after the window ends.
    localparam int ACT_LAG = ACT_CYC;
    localparam int PRE_LAG = PRE_CYC;
    localparam int ACT_BACK = ACT_CYC + 1;
    localparam int PRE_BACK = PRE_CYC + 1;
    logic ck_q;
    logic ap;
    logic [1:0] b_q;
    logic [2:0] cm;
    sbcsm_bank_state_type sb;
    sbcsm_bank_state_type nb;
    logic open_any;
    // Clock enable and bank one edge old; an edge counts only with enable high twice.
    always_ff @(posedge mem_clock)
    begin
        ck_q <= pins.cke;
        b_q <= pins[1:0];
    end
    // An edge that does not count reads as a no-operation.
    assign cm = (!pins.cs_n && pins.cke && ck_q && dev_state == DEV_NORMAL) ?
        pins[6:4] : STROBE_NOP;
    assign ap = pins.auto_precharge_bit;
    assign sb = bank_state[pins[1:0]];
    assign nb = bank_state[b_q];
    // An untimed open row is sure to block a refresh on this very edge.
    assign open_any = (bank_state[0] == BANK_ACTIVE) || (bank_state[1] == BANK_ACTIVE) ||
        (bank_state[2] == BANK_ACTIVE) || (bank_state[3] == BANK_ACTIVE);
    default clocking @(posedge mem_clock);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    // Timed windows seen from the addressed bank.
    sequence s_open;
        nb == BANK_ACTIVATING ##ACT_LAG bank_state[$past(pins[1:0], ACT_BACK)] == BANK_ACTIVE;
    endsequence
    sequence s_shut;
        nb == BANK_PRECHARGING ##PRE_LAG bank_state[$past(pins[1:0], PRE_BACK)] == BANK_IDLE;
    endsequence
    property p_inh; pins.cs_n && sb == BANK_IDLE |=> nb == BANK_IDLE; endproperty
    property p_nop; !pins.cs_n && pins[6:4] == STROBE_NOP |=> !command_illegal; endproperty
    property p_act; cm == STROBE_ACTIVE && sb == BANK_IDLE |=> s_open; endproperty
    property p_rd; cm == STROBE_READ && sb == BANK_IDLE |=> command_illegal; endproperty
    property p_ap; cm == STROBE_READ && ap && sb == BANK_ACTIVE |=> nb == BANK_READ_AP; endproperty
    property p_cut;
        cm == STROBE_PRECHARGE && !ap && (sb == BANK_READ || sb == BANK_WRITE) |=> s_shut;
    endproperty
    property p_pid; cm == STROBE_PRECHARGE && sb == BANK_IDLE |=> nb == BANK_IDLE; endproperty
    property p_ref; cm == STROBE_REFRESH && open_any |=> command_illegal; endproperty
    a_inh: assert property (p_inh) else $error("inhibit moved a bank");
    a_nop: assert property (p_nop) else $error("nop flagged");
    a_act: assert property (p_act) else $error("activate window wrong");
    a_rd: assert property (p_rd) else $error("read to idle bank taken");
    a_ap: assert property (p_ap) else $error("auto precharge read wrong");
    a_cut: assert property (p_cut) else $error("burst cut wrong");
    a_pid: assert property (p_pid) else $error("idle bank moved");
    a_ref: assert property (p_ref) else $error("refresh with open bank");
endmodule : sbcsm_asserts

bind sbcsm_bank_tracker sbcsm_asserts #(.ACT_CYC(ACT_CYC), .PRE_CYC(PRE_CYC)) u_asserts (
    .mem_clock(mem_clock), .rstn(rstn), .pins(pins), .bank_state(bank_state),
    .dev_state(dev_state), .command_illegal(command_illegal));

// >>> test/sbcsm_ctrl_model.sv
// Memory controller stand-in that drives the link command pins.
`timescale 1ns/10ps
module sbcsm_ctrl_model
    import sbcsm_pkg::*;
(
    // Link clock in, command pins out
    input wire logic mem_clock,
    output sbcsm_pins_type pins
);
    logic hv = 1'b0;
    sbcsm_pins_type nx;
    // Deselected lines wander between commands, so no stale level is trusted.
    initial pins = 8'h88;
    always @(posedge mem_clock)
    begin
        #2;
        pins <= hv ? nx : {1'b1, ~pins[6:4], 1'b1, ~pins[2:0]};
        hv <= 1'b0;
    end
    // One command per call; callers keep sequences legal unless a refusal is wanted.
    task automatic send(input logic [2:0] st, input logic [1:0] bk, input logic ap);
        nx = {1'b0, st, 1'b1, ap, bk};
        hv = 1'b1;
        @(posedge mem_clock);
        #3;
    endtask : send
endmodule : sbcsm_ctrl_model

// >>> test/testbench.sv
// Bench: random banks through the controller model, compared with a bank model.
`timescale 1ns/10ps
module testbench
    import sbcsm_pkg::*;
;
    logic clock = 1'b0;
    logic mem_clock = 1'b0;
    logic rstn = 1'b0;
    logic command_illegal;
    logic status_valid;
    logic [15:0] r = 16'haaa6;
    logic [1:0] b;
    logic [1:0] o;
    int fails = 0;
    int tests_run = 0;
    sbcsm_pins_type pins;
    sbcsm_status_type status;
    sbcsm_dev_state_type dev_state;
    sbcsm_bank_state_type [NUM_BANKS-1:0] bank_state;
    sbcsm_bank_state_type [NUM_BANKS-1:0] mb = '0;
    // The two clocks run at unequal periods, 40 ns and 64 ns, and their rising edges never coincide.
    always #20 clock = ~clock;
    always #32 mem_clock = ~mem_clock;
    sbcsm_bank_tracker #(.PRE_CYC(2), .ACT_CYC(2)) i_dut (.clock(clock), .rstn(rstn),
        .mem_clock(mem_clock), .pins(pins), .bank_state(bank_state), .dev_state(dev_state),
        .command_illegal(command_illegal), .status(status), .status_valid(status_valid));
    sbcsm_ctrl_model i_ctl (.mem_clock(mem_clock), .pins(pins));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lf(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lf
    task automatic chk(input string n, input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    // Waits n link edges, then compares every bank with the model.
    task automatic look(input int n);
        repeat (n) @(posedge mem_clock);
        #3;
        chk("bank_state", bank_state, mb);
    endtask : look
    // Checks the illegal pulse and the device state one edge after a command.
    task automatic ill(input logic v, input sbcsm_dev_state_type d);
        @(posedge mem_clock);
        #3;
        chk("command_illegal", command_illegal, v);
        chk("dev_state", dev_state, d);
    endtask : ill
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // Watchdog far beyond the expected run length.
    initial
    begin
        #2000000;
        fails++;
        wrap_up();
    end
    initial
    begin
        repeat (8) @(posedge clock);
        #2;
        rstn = 1'b1;
        repeat (6) @(posedge mem_clock);
        // Calls start past the model's drive point, so each command lands one edge later.
        #3;
        for (int k = 0; k < 4; k++)
        begin
            r = lf(r);
            b = r[1:0];
            o = b + 2'h1;
            i_ctl.send(STROBE_ACTIVE, b, 1'b0);
            i_ctl.send(STROBE_ACTIVE, o, 1'b0);
            mb[b] = BANK_ACTIVE;
            mb[o] = BANK_ACTIVE;
            look(4);
            i_ctl.send(k[0] ? STROBE_WRITE : STROBE_READ, b, 1'b0);
            i_ctl.send(STROBE_PRECHARGE, b, 1'b0);
            mb[b] = BANK_IDLE;
            look(4);
            i_ctl.send(k[0] ? STROBE_READ : STROBE_WRITE, o, 1'b1);
            mb[o] = BANK_IDLE;
            look(9);
            i_ctl.send(STROBE_READ, b, 1'b0);
            ill(1'b1, DEV_NORMAL);
            i_ctl.send(STROBE_PRECHARGE, o, 1'b0);
            ill(1'b0, DEV_NORMAL);
        end
        i_ctl.send(STROBE_ACTIVE, b, 1'b0);
        mb[b] = BANK_ACTIVE;
        look(4);
        i_ctl.send(STROBE_READ, b, 1'b0);
        i_ctl.send(STROBE_BURST_TERM, o, 1'b0);
        look(1);
        i_ctl.send(STROBE_REFRESH, o, 1'b0);
        ill(1'b1, DEV_NORMAL);
        i_ctl.send(STROBE_PRECHARGE, o, 1'b1);
        ill(1'b0, DEV_PRECHARGE_ALL);
        mb = '0;
        look(4);
        i_ctl.send(STROBE_REFRESH, b, 1'b0);
        ill(1'b0, DEV_REFRESHING);
        i_ctl.send(STROBE_NOP, b, 1'b0);
        look(4);
        i_ctl.send(STROBE_MODE_LOAD, b, 1'b0);
        ill(1'b0, DEV_MODE_LOAD);
        i_ctl.send(STROBE_NOP, o, 1'b0);
        look(4);
        // The system copy is checked on the second snapshot, the first may be stale.
        repeat (2)
        begin
            @(posedge clock);
            #3;
            for (int n = 0; n < 99 && status_valid !== 1'b1; n++)
            begin
                @(posedge clock);
                #3;
            end
        end
        chk("status_valid", status_valid, 1'b1);
        chk("status_bank", status.bank, mb);
        chk("status_flags", {status.dev, status.illegal_seen}, {DEV_NORMAL, 1'b1});
        wrap_up();
    end
endmodule : testbench
